//--- rtl/crsx_pkg.sv
/*
 * Shared constants and carrier types of the call, return and system
 * control execution unit.
 * Assumes a single 40 MHz clock and an internal byte-wide memory.
 */
package crsx_pkg;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_SWI = 8'hfc;
  localparam logic [7:0] OP_PLAIN_RET = 8'hf8;
  localparam logic [7:0] OP_EXC_RET = 8'hf9;
  localparam logic [7:0] OP_SKIP_RET = 8'hfa;
  localparam logic [7:0] OP_NOP = 8'hff;
  localparam logic [7:0] OP_ESCAPE = 8'hce;
  localparam logic [7:0] OP_HALT = 8'hae;
  localparam logic [7:0] OP_SLEEP = 8'haf;

  // ==========================================================
  // instruction lengths in bytes
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [15:0] LEN_TWO = 16'h0002;
  localparam logic [15:0] SKIP_ADD = 16'h0002;

  // ==========================================================
  // cycle counts
  localparam logic [3:0] CYC_SWI_MIN = 4'h7;
  localparam logic [3:0] CYC_SWI_MAX = 4'h8;
  localparam logic [3:0] CYC_RET_MIN = 4'h3;
  localparam logic [3:0] CYC_RET_MAX = 4'h4;
  localparam logic [3:0] CYC_EXCEPTION_RETURN_MIN = 4'h4;
  localparam logic [3:0] CYC_EXCEPTION_RETURN_MAX = 4'h5;
  localparam logic [3:0] CYC_SKIP_RETURN_MIN = 4'h5;
  localparam logic [3:0] CYC_SKIP_RETURN_MAX = 4'h6;
  localparam logic [3:0] CYC_NOP = 4'h2;
  localparam logic [3:0] CYC_HALT = 4'h3;
  localparam logic [3:0] CYC_SLEEP = 4'h3;

  // ==========================================================
  // stack byte counts and interrupt vector page
  localparam logic [3:0] PUSH_MIN = 4'h3;
  localparam logic [3:0] PUSH_MAX = 4'h4;
  localparam logic [3:0] POP_RET_MIN = 4'h2;
  localparam logic [3:0] POP_RET_MAX = 4'h3;
  localparam logic [3:0] POP_EXCEPTION_RETURN_MIN = 4'h3;
  localparam logic [3:0] POP_EXCEPTION_RETURN_MAX = 4'h4;
  localparam logic [7:0] PAGE_ZERO = 8'h00;

  // ==========================================================
  // reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] BANK_RESET = 8'h00;

  // ==========================================================
  // memory model encoding of the configuration input
  typedef enum logic [1:0] {
    CRSX_SMALL = 2'h0,
    CRSX_LARGE_MIN = 2'h1,
    CRSX_LARGE_MAX = 2'h2
  } crsx_model_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } crsx_mem_req_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] flags;
    logic [7:0] active_code_bank;
    logic [7:0] pending_code_bank;
  } crsx_arch_t;

endpackage : crsx_pkg

//--- rtl/crsx_model_latch.sv
/*
 * Synchronises the static memory model strap and catches it once after
 * reset release.
 * Assumes the strap is steady from reset onward.
 */
`timescale 1ns/1ps
module crsx_model_latch (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // strap
  input wire logic [1:0] cfg_model_i,
  // caught model
  output logic [1:0] model_o,
  output logic model_valid_o
);

  logic [1:0] s1_q, s1_d, s2_q, s2_d;
  logic v1_q, v1_d, v2_q, v2_d;
  logic [1:0] model_q, model_d;
  logic valid_q, valid_d;

  // ==========================================================
  // next values
  always_comb
  begin
    s1_d = cfg_model_i;
    s2_d = s1_q;
    v1_d = 1'b1;
    v2_d = v1_q;
    model_d = model_q;
    valid_d = valid_q;
    if (v2_q && !valid_q)
    begin
      model_d = s2_q;
      valid_d = 1'b1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      v1_q <= 1'b0;
      v2_q <= 1'b0;
      model_q <= 2'h0;
      valid_q <= 1'b0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      v1_q <= v1_d;
      v2_q <= v2_d;
      model_q <= model_d;
      valid_q <= valid_d;
    end
  end

  assign model_o = model_q;
  assign model_valid_o = valid_q;

endmodule : crsx_model_latch

//--- rtl/crsx_exec.sv
/*
 * Execution unit for software interrupt, returns, no-operation, halt
 * and sleep, with its own program counter, stack pointer, flags and
 * code bank registers.
 * Assumes internal memory with asynchronous read of mem_req_o.addr.
 */
// Function
// - small/minimum interrupt pushes PC high, low, flags; stack minus three; 7 cycles
// - interrupt loads PC from page zero kk, kk+1; large copies pending bank
// - maximum interrupt pushes bank, PC high, low, flags; stack minus four; 8 cycles
// - plain return pops PC low then high, stack plus two, 3 cycles
// - maximum plain return also pops bank into both banks, plus three, 4 cycles
// - exception return pops flags, PC low, high, stack plus three, 4 cycles
// - maximum exception return also pops bank, stack plus four, 5 cycles
// - skip return is plain return then PC plus two; 5 or 6 cycles
// - nop 2 cycles; halt and sleep escape-prefixed, 3 cycles, enter states
`timescale 1ns/1ps
module crsx_exec (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // configuration strap and wake
  input wire logic [1:0] cfg_model_i,
  input wire logic wake_i,
  // instruction issue
  input wire logic start_i,
  input wire logic [7:0] op_byte0_i,
  input wire logic [7:0] op_byte1_i,
  // memory
  output crsx_pkg::crsx_mem_req_t mem_req_o,
  input wire logic [7:0] mem_rdata_i,
  // status
  output crsx_pkg::crsx_arch_t arch_o,
  output logic ready_o,
  output logic done_o,
  output logic illegal_o,
  output logic halted_o,
  output logic sleeping_o
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_HALT = 4'b0100,
    ST_SLEEP = 4'b1000
  } crsx_state_t;

  typedef enum logic [6:0] {
    K_SWI = 7'b0000001,
    K_RET = 7'b0000010,
    K_EXCEPTION_RETURN = 7'b0000100,
    K_SKIP_RETURN = 7'b0001000,
    K_NOP = 7'b0010000,
    K_HALT = 7'b0100000,
    K_SLEEP = 7'b1000000
  } crsx_kind_t;

  logic [1:0] model;
  logic model_valid;
  logic is_max, is_large;

  crsx_state_t state_q, state_d;
  crsx_kind_t kind_q, kind_d;
  crsx_pkg::crsx_arch_t arch_q, arch_d;
  crsx_pkg::crsx_mem_req_t mem_q, mem_d;
  logic [7:0] kk_q, kk_d;
  logic [3:0] step_q, step_d;
  logic [3:0] last_q, last_d;
  logic [1:0] pidx_q, pidx_d;
  logic [7:0] pop_q [4];
  logic [7:0] pop_d [4];
  logic ready_q, ready_d, done_q, done_d, ill_q, ill_d;
  logic halt_q, halt_d, sleep_q, sleep_d;
  logic [3:0] npush, npop;

  crsx_model_latch u_model (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .cfg_model_i(cfg_model_i),
    .model_o(model),
    .model_valid_o(model_valid)
  );

  assign is_max = (model == crsx_pkg::CRSX_LARGE_MAX);
  assign is_large = (model != crsx_pkg::CRSX_SMALL);
  assign npush = is_max ? crsx_pkg::PUSH_MAX : crsx_pkg::PUSH_MIN;
  assign npop = (kind_q == K_EXCEPTION_RETURN) ?
                (is_max ? crsx_pkg::POP_EXCEPTION_RETURN_MAX : crsx_pkg::POP_EXCEPTION_RETURN_MIN) :
                (is_max ? crsx_pkg::POP_RET_MAX : crsx_pkg::POP_RET_MIN);

  // ==========================================================
  // stacked byte for interrupt push number n
  function automatic logic [7:0] push_byte(input logic [3:0] n,
                                           input logic mx,
                                           input crsx_pkg::crsx_arch_t a);
    logic [3:0] k;
    k = mx ? n : n + 4'h1;
    case (k)
      4'h1: push_byte = a.active_code_bank;
      4'h2: push_byte = a.pc[15:8];
      4'h3: push_byte = a.pc[7:0];
      default: push_byte = a.flags;
    endcase
  endfunction : push_byte

  // ==========================================================
  // next values
  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    arch_d = arch_q;
    kk_d = kk_q;
    step_d = step_q;
    last_d = last_q;
    pidx_d = pidx_q;
    for (int i = 0; i < 4; i++)
    begin
      pop_d[i] = pop_q[i];
    end
    mem_d = '0;
    done_d = 1'b0;
    ill_d = 1'b0;
    // capture read data of the access issued last cycle
    if (mem_q.rd)
    begin
      pop_d[pidx_q] = mem_rdata_i;
      pidx_d = pidx_q + 2'h1;
    end
    case (state_q)
      ST_IDLE:
      begin
        if (start_i && ready_q)
        begin
          step_d = 4'h1;
          pidx_d = 2'h0;
          kk_d = op_byte1_i;
          state_d = ST_EXEC;
          arch_d.pc = arch_q.pc + crsx_pkg::LEN_ONE;
          case (op_byte0_i)
            crsx_pkg::OP_SWI:
            begin
              kind_d = K_SWI;
              arch_d.pc = arch_q.pc + crsx_pkg::LEN_TWO;
              last_d = is_max ? crsx_pkg::CYC_SWI_MAX : crsx_pkg::CYC_SWI_MIN;
            end
            crsx_pkg::OP_PLAIN_RET:
            begin
              kind_d = K_RET;
              last_d = is_max ? crsx_pkg::CYC_RET_MAX : crsx_pkg::CYC_RET_MIN;
            end
            crsx_pkg::OP_EXC_RET:
            begin
              kind_d = K_EXCEPTION_RETURN;
              last_d = is_max ? crsx_pkg::CYC_EXCEPTION_RETURN_MAX : crsx_pkg::CYC_EXCEPTION_RETURN_MIN;
            end
            crsx_pkg::OP_SKIP_RET:
            begin
              kind_d = K_SKIP_RETURN;
              last_d = is_max ? crsx_pkg::CYC_SKIP_RETURN_MAX : crsx_pkg::CYC_SKIP_RETURN_MIN;
            end
            crsx_pkg::OP_NOP:
            begin
              kind_d = K_NOP;
              last_d = crsx_pkg::CYC_NOP;
            end
            crsx_pkg::OP_ESCAPE:
            begin
              arch_d.pc = arch_q.pc + crsx_pkg::LEN_TWO;
              kind_d = (op_byte1_i == crsx_pkg::OP_HALT) ? K_HALT : K_SLEEP;
              last_d = (op_byte1_i == crsx_pkg::OP_HALT) ?
                       crsx_pkg::CYC_HALT : crsx_pkg::CYC_SLEEP;
              if (op_byte1_i != crsx_pkg::OP_HALT && op_byte1_i != crsx_pkg::OP_SLEEP)
              begin
                state_d = ST_IDLE;
                arch_d.pc = arch_q.pc;
                done_d = 1'b1;
                ill_d = 1'b1;
              end
            end
            default:
            begin
              state_d = ST_IDLE;
              arch_d.pc = arch_q.pc;
              done_d = 1'b1;
              ill_d = 1'b1;
            end
          endcase
        end
      end
      ST_EXEC:
      begin
        step_d = step_q + 4'h1;
        case (kind_q)
          K_SWI:
          begin
            if (step_q <= npush)
            begin
              mem_d.wr = 1'b1;
              mem_d.addr = arch_q.sp - {12'h000, step_q};
              mem_d.wdata = push_byte(step_q, is_max, arch_q);
            end
            else if (step_q == npush + 4'h1 || step_q == npush + 4'h2)
            begin
              mem_d.rd = 1'b1;
              mem_d.addr = {crsx_pkg::PAGE_ZERO, kk_q} + {12'h000, step_q - npush - 4'h1};
            end
            if (step_q == last_q)
            begin
              arch_d.sp = arch_q.sp - {12'h000, npush};
              arch_d.pc = {pop_d[1], pop_d[0]};
              if (is_large)
              begin
                arch_d.active_code_bank = arch_q.pending_code_bank;
              end
            end
          end
          K_RET, K_EXCEPTION_RETURN, K_SKIP_RETURN:
          begin
            if (step_q <= npop)
            begin
              mem_d.rd = 1'b1;
              mem_d.addr = arch_q.sp + {12'h000, step_q - 4'h1};
            end
            if (step_q == last_q)
            begin
              arch_d.sp = arch_q.sp + {12'h000, npop};
              if (kind_q == K_EXCEPTION_RETURN)
              begin
                arch_d.flags = pop_d[0];
                arch_d.pc = {pop_d[2], pop_d[1]};
              end
              else
              begin
                arch_d.pc = {pop_d[1], pop_d[0]};
              end
              if (kind_q == K_SKIP_RETURN)
              begin
                arch_d.pc = {pop_d[1], pop_d[0]} + crsx_pkg::SKIP_ADD;
              end
              if (is_max)
              begin
                arch_d.active_code_bank = pop_d[npop[1:0] - 2'h1];
                arch_d.pending_code_bank = pop_d[npop[1:0] - 2'h1];
              end
            end
          end
          default:
          begin
          end
        endcase
        if (step_q == last_q)
        begin
          done_d = 1'b1;
          case (kind_q)
            K_HALT: state_d = ST_HALT;
            K_SLEEP: state_d = ST_SLEEP;
            default: state_d = ST_IDLE;
          endcase
        end
      end
      ST_HALT, ST_SLEEP:
      begin
        if (wake_i)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    ready_d = (state_d == ST_IDLE) && model_valid;
    halt_d = (state_d == ST_HALT);
    sleep_d = (state_d == ST_SLEEP);
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      state_q <= ST_IDLE;
      kind_q <= K_NOP;
      arch_q <= '{pc: crsx_pkg::PC_RESET, sp: crsx_pkg::SP_RESET,
                  flags: crsx_pkg::FLAGS_RESET,
                  active_code_bank: crsx_pkg::BANK_RESET,
                  pending_code_bank: crsx_pkg::BANK_RESET};
      mem_q <= '0;
      kk_q <= 8'h00;
      step_q <= 4'h0;
      last_q <= 4'h0;
      pidx_q <= 2'h0;
      for (int i = 0; i < 4; i++)
      begin
        pop_q[i] <= 8'h00;
      end
      ready_q <= 1'b0;
      done_q <= 1'b0;
      ill_q <= 1'b0;
      halt_q <= 1'b0;
      sleep_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      arch_q <= arch_d;
      mem_q <= mem_d;
      kk_q <= kk_d;
      step_q <= step_d;
      last_q <= last_d;
      pidx_q <= pidx_d;
      for (int i = 0; i < 4; i++)
      begin
        pop_q[i] <= pop_d[i];
      end
      ready_q <= ready_d;
      done_q <= done_d;
      ill_q <= ill_d;
      halt_q <= halt_d;
      sleep_q <= sleep_d;
    end
  end

  assign mem_req_o = mem_q;
  assign arch_o = arch_q;
  assign ready_o = ready_q;
  assign done_o = done_q;
  assign illegal_o = ill_q;
  assign halted_o = halt_q;
  assign sleeping_o = sleep_q;

endmodule : crsx_exec

//--- tb/crsx_exec_monitor.sv
/* Port checker for crsx_exec.
   Assumes a bind from the bench top and a model strap held static. */
`timescale 1ns/1ps
module crsx_exec_monitor (
  // clock, reset, strap
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [1:0] cfg_model_i,
  // issue
  input wire logic start_i,
  input wire logic [7:0] op_byte0_i,
  input wire logic [7:0] op_byte1_i,
  // memory
  input crsx_pkg::crsx_mem_req_t mem_req_o,
  input wire logic [7:0] mem_rdata_i,
  // status
  input crsx_pkg::crsx_arch_t arch_o,
  input wire logic ready_o,
  input wire logic done_o,
  input wire logic halted_o,
  input wire logic sleeping_o
);
  logic acc;
  logic mx;
  logic [7:0] last_op_q;
  assign acc = start_i && ready_o;
  assign mx = cfg_model_i == 2'h2;
  // last accepted opcode
  always_ff @(posedge mclk_i)
  begin
    if (acc)
    begin
      last_op_q <= op_byte0_i;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // ==========
  // properties
  chk_swi_min_time: assert property (acc && op_byte0_i == 8'hfc && !mx
    |-> ##1 !done_o [*7] ##1 done_o) else $error("interrupt timing wrong");
  chk_swi_push_top: assert property (acc && op_byte0_i == 8'hfc
    |-> ##2 mem_req_o.wr && mem_req_o.addr == $past(arch_o.sp) - 16'h1
    && mem_req_o.wdata == (mx ? arch_o.active_code_bank : arch_o.pc[15:8]))
    else $error("first push wrong");
  chk_ret_sp_step: assert property (acc && op_byte0_i == 8'hf8 && !mx
    |-> ##4 done_o && arch_o.sp == $past(arch_o.sp, 4) + 16'h2) else $error("return stack wrong");
  chk_skip_pc_add: assert property (acc && op_byte0_i == 8'hfa && !mx
    |-> ##2 (mem_req_o.rd && mem_req_o.addr == arch_o.sp) ##4 (done_o
    && arch_o.pc == {$past(mem_rdata_i, 3), $past(mem_rdata_i, 4)} + 16'h2))
    else $error("skip return pc wrong");
  chk_max_ret_bank: assert property (acc && op_byte0_i == 8'hf8 && mx
    |-> ##5 done_o && arch_o.active_code_bank == $past(mem_rdata_i)
    && arch_o.pending_code_bank == $past(mem_rdata_i)) else $error("return bank wrong");
  chk_exc_flag_pop: assert property (acc && op_byte0_i == 8'hf9 && !mx
    |-> ##2 (mem_req_o.rd && mem_req_o.addr == arch_o.sp) ##3 (done_o
    && arch_o.flags == $past(mem_rdata_i, 3))) else $error("flag restore wrong");
  chk_flags_kept: assert property ($changed(arch_o.flags)
    |-> done_o && last_op_q == 8'hf9) else $error("flags changed");
  chk_halt_state: assert property (acc && op_byte0_i == 8'hce && op_byte1_i[7:1] == 7'h57
    |-> ##4 done_o && halted_o == !$past(op_byte1_i[0], 4)
    && sleeping_o == $past(op_byte1_i[0], 4)) else $error("halt or sleep entry wrong");
endmodule : crsx_exec_monitor

//--- tb/crsx_mem_model.sv
/* Byte memory partner of the execution unit.
   Assumes requests from crsx_exec on the same clock. */
`timescale 1ns/1ps
module crsx_mem_model (
  // clock
  input wire logic mclk_i,
  // request and read data
  input crsx_pkg::crsx_mem_req_t mem_req_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'ha5;
  // idle read data toggles, never holds the last byte
  assign rdata_o = mem_req_i.rd ? mem[mem_req_i.addr] : ~last_q;
  always @(posedge mclk_i)
  begin
    if (mem_req_i.wr)
    begin
      mem[mem_req_i.addr] <= mem_req_i.wdata;
    end
    last_q <= rdata_o;
  end
endmodule : crsx_mem_model

//--- tb/tb.sv
/* Bench for crsx_exec with a byte memory partner and bound checker.
   Assumes package, design, partner and checker compile first. */
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0] op0;
    logic [7:0] op1;
    logic [3:0] cmin;
    logic [3:0] cmax;
    logic ill;
  } crsx_row_t;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [1:0] cfg_model_i = 2'h0;
  logic wake_i = 1'b0;
  logic start_i = 1'b0;
  logic [7:0] op_byte0_i = 8'h00;
  logic [7:0] op_byte1_i = 8'h00;
  crsx_pkg::crsx_mem_req_t mem_req_o;
  crsx_pkg::crsx_arch_t arch_o;
  logic [7:0] mem_rdata_i;
  logic ready_o, done_o, illegal_o, halted_o, sleeping_o;
  logic [15:0] epc, esp;
  logic [7:0] efl, eab, epb;
  logic [7:0] sh [0:65535];
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  crsx_row_t rows [11] = '{
    '{8'hff, 8'h00, 4'h2, 4'h2, 1'b0}, '{8'hfc, 8'h20, 4'h7, 4'h8, 1'b0},
    '{8'hfa, 8'h00, 4'h5, 4'h6, 1'b0}, '{8'hfc, 8'h41, 4'h7, 4'h8, 1'b0},
    '{8'hf9, 8'h00, 4'h4, 4'h5, 1'b0}, '{8'hfc, 8'hff, 4'h7, 4'h8, 1'b0},
    '{8'hf8, 8'h00, 4'h3, 4'h4, 1'b0}, '{8'hce, 8'hae, 4'h3, 4'h3, 1'b0},
    '{8'hce, 8'haf, 4'h3, 4'h3, 1'b0}, '{8'hce, 8'h00, 4'h0, 4'h0, 1'b1},
    '{8'h00, 8'h00, 4'h0, 4'h0, 1'b1}};
  crsx_exec i_crsx_exec (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .cfg_model_i(cfg_model_i), .wake_i(wake_i),
    .start_i(start_i), .op_byte0_i(op_byte0_i), .op_byte1_i(op_byte1_i),
    .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i), .arch_o(arch_o), .ready_o(ready_o),
    .done_o(done_o), .illegal_o(illegal_o), .halted_o(halted_o), .sleeping_o(sleeping_o));
  crsx_mem_model i_crsx_mem_model (
    .mclk_i(mclk_i), .mem_req_i(mem_req_o), .rdata_o(mem_rdata_i));
  always #12.5 mclk_i = ~mclk_i;
  // ==========
  // hang guard
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset(input logic [1:0] m);
    int n;
    resetn_i = 1'b0;
    start_i = 1'b0;
    cfg_model_i = m;
    repeat (5) @(negedge mclk_i);
    check(arch_o, 0);
    check({ready_o, done_o, illegal_o, halted_o, sleeping_o}, 0);
    check(mem_req_o, 0);
    resetn_i = 1'b1;
    {epc, esp, efl, eab, epb} = '0;
    n = 0;
    while (ready_o !== 1'b1 && n < 9)
    begin
      @(negedge mclk_i);
      n++;
    end
    check(n, 4);
  endtask : do_reset
  // ==========
  // reference of one instruction
  task automatic ref_step(input crsx_row_t r, input logic mx);
    logic [15:0] p;
    p = epc + ((r.op0 inside {8'hfc, 8'hce}) ? 16'h2 : 16'h1);
    if (r.ill)
      p = epc;
    if (r.op0 == 8'hfc)
    begin
      if (mx)
      begin
        esp = esp - 16'h1;
        sh[esp] = eab;
      end
      sh[esp - 16'h1] = p[15:8];
      sh[esp - 16'h2] = p[7:0];
      esp = esp - 16'h3;
      sh[esp] = efl;
      p = {sh[{8'h00, r.op1} + 16'h1], sh[{8'h00, r.op1}]};
      if (cfg_model_i != 2'h0)
        eab = epb;
    end
    if (r.op0 inside {8'hf8, 8'hf9, 8'hfa})
    begin
      if (r.op0 == 8'hf9)
      begin
        efl = sh[esp];
        esp = esp + 16'h1;
      end
      p = {sh[esp + 16'h1], sh[esp]};
      esp = esp + 16'h2;
      if (mx)
      begin
        eab = sh[esp];
        epb = eab;
        esp = esp + 16'h1;
      end
      if (r.op0 == 8'hfa)
        p = p + 16'h2;
    end
    epc = p;
  endtask : ref_step
  task automatic issue(input crsx_row_t r);
    int n;
    logic mx;
    mx = cfg_model_i == 2'h2;
    n = 0;
    while (ready_o !== 1'b1 && n < 20)
    begin
      @(negedge mclk_i);
      n++;
    end
    start_i = 1'b1;
    op_byte0_i = r.op0;
    op_byte1_i = r.op1;
    @(negedge mclk_i);
    start_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 20)
    begin
      @(negedge mclk_i);
      n++;
    end
    ref_step(r, mx);
    check(n, mx ? r.cmax : r.cmin);
    check(illegal_o, r.ill);
    check(arch_o, {epc, esp, efl, eab, epb});
    if (r.op0 == 8'hce && !r.ill)
    begin
      check({halted_o, sleeping_o}, {r.op1 == 8'hae, r.op1 == 8'haf});
      wake_i = 1'b1;
      @(negedge mclk_i);
      wake_i = 1'b0;
      check({halted_o, sleeping_o, ready_o}, 3'b001);
    end
  endtask : issue
  // ==========
  // main sequence
  initial
  begin
    for (int i = 0; i < 65536; i++)
    begin
      sh[i] = i[7:0] ^ i[15:8] ^ 8'h96;
      i_crsx_mem_model.mem[i] = sh[i];
    end
    for (int m = 0; m < 4; m++)
    begin
      do_reset(m[1:0]);
      foreach (rows[r]) issue(rows[r]);
    end
    // start held high: only taken when idle
    start_i = 1'b1;
    op_byte0_i = 8'hff;
    repeat (3) @(negedge mclk_i);
    check({done_o, arch_o.pc}, {1'b1, epc + 16'h1});
    // reset in mid-interrupt, start still held
    op_byte0_i = 8'hfc;
    repeat (3) @(negedge mclk_i);
    do_reset(2'h2);
    tally_and_finish();
  end
endmodule : tb
bind crsx_exec crsx_exec_monitor i_crsx_exec_monitor (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .cfg_model_i(cfg_model_i), .start_i(start_i),
  .op_byte0_i(op_byte0_i), .op_byte1_i(op_byte1_i), .mem_req_o(mem_req_o),
  .mem_rdata_i(mem_rdata_i), .arch_o(arch_o), .ready_o(ready_o), .done_o(done_o),
  .halted_o(halted_o), .sleeping_o(sleeping_o));
